/* hdl/eps_driver.sv */
// Standalone energy pulse output and stepper motor drive
`timescale 1ns/1ns

// Behaviour
// - CALIB_PULSE_PIN carries energy pulses in modes 2, 3
// - Mode 2: CALIB_PULSE_PIN follows energy pulse directly
// - Mode 2 pulse keeps source 50 percent duty
// - Mode 3 CALIB_PULSE_PIN pulses are 31.25 ms wide
// - Modes 2, 3 drive both motor pins
// - Motor path: divider, one-shot, phase decoder
// - Motor pulse 31.25 or 156.25 ms
// - Motor divider from long and rate selects
// - Motor pulses alternate between phase A, B
// - Negative power inverts both motor pins
// - No load holds both motor pins low
// - No load: mode 2 CALIB_PULSE_PIN runs, mode 3 stops
module eps_driver #(
  parameter int unsigned CNT_W          = eps_pkg::CNT_W_DEF,
  parameter int unsigned SHORT_PULSE_CYC = eps_pkg::SHORT_PULSE_CYC,
  parameter int unsigned LONG_PULSE_CYC  = eps_pkg::LONG_PULSE_CYC
) (
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic                       CE,
  input  wire logic                       ACTIVE_ENERGY_PULSE,
  input  wire logic                       POWER_NEGATIVE,
  input  wire logic                       NO_LOAD_FLAG,
  input  wire logic [eps_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [eps_pkg::DATA_W-1:0] WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic      [eps_pkg::DATA_W-1:0] RDATA,
  output logic                            CALIB_PULSE_PIN,
  output logic                            MOTOR_OUT_POS,
  output logic                            MOTOR_OUT_NEG
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (CNT_W < 2 || CNT_W > 31) begin : g_chk_w
    $error("eps_driver: CNT_W out of range");
  end
  if (SHORT_PULSE_CYC < 1 || SHORT_PULSE_CYC >= (1 << CNT_W)) begin : g_chk_s
    $error("eps_driver: SHORT_PULSE_CYC does not fit");
  end
  if (LONG_PULSE_CYC < 1 || LONG_PULSE_CYC >= (1 << CNT_W)) begin : g_chk_l
    $error("eps_driver: LONG_PULSE_CYC does not fit");
  end

  localparam int unsigned DW = eps_pkg::DIV_W;

  // ****************************************************************
  // Divider decode
  // ****************************************************************
  function automatic logic [DW-1:0] eps_div(
    input logic       long_sel,
    input logic [1:0] rate_sel
  );
    logic [DW-1:0] d;
    d = eps_pkg::DIV_64;
    case ({long_sel, rate_sel})
      3'h0:    d = eps_pkg::DIV_64;
      3'h1:    d = eps_pkg::DIV_128;
      3'h2:    d = eps_pkg::DIV_32;
      3'h3:    d = eps_pkg::DIV_256;
      3'h4:    d = eps_pkg::DIV_640;
      3'h5:    d = eps_pkg::DIV_1280;
      3'h6:    d = eps_pkg::DIV_320;
      3'h7:    d = eps_pkg::DIV_2560;
      default: d = eps_pkg::DIV_64;
    endcase
    return d;
  endfunction : eps_div

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  logic [7:0] cfg_q;
  logic [1:0] output_pin_mode_sel;
  logic [1:0] pulse_rate_sel;
  logic       long_pulse_sel;

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_q <= eps_pkg::CFG_RESET;
    end else if (CE) begin
      if (WR && ADDR == eps_pkg::REG_CFG) begin
        cfg_q <= WDATA;
      end
    end
  end

  assign output_pin_mode_sel = cfg_q[eps_pkg::CFG_MODE_LSB +: 2];
  assign pulse_rate_sel      = cfg_q[eps_pkg::CFG_RATE_LSB +: 2];
  assign long_pulse_sel      = cfg_q[eps_pkg::CFG_LONG_BIT];

  logic mode_direct;
  logic mode_fixed;
  logic standalone;

  assign mode_direct = (output_pin_mode_sel == eps_pkg::MODE_DIRECT);
  assign mode_fixed  = (output_pin_mode_sel == eps_pkg::MODE_FIXED);
  assign standalone  = mode_direct | mode_fixed;

  // ****************************************************************
  // Energy pulse edge detect
  // ****************************************************************
  // Source comes from the energy accumulator on this clock, no sync
  // Edge register resets to the idle level, so no false edge follows
  logic aw_q;
  logic aw_rise;

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_q <= 1'b0;
    end else if (CE) begin
      aw_q <= ACTIVE_ENERGY_PULSE;
    end
  end

  assign aw_rise = ACTIVE_ENERGY_PULSE & ~aw_q;

  // ****************************************************************
  // Rate dividers: index 0 feeds the CALIB_PULSE_PIN, index 1 the motor
  // ****************************************************************
  logic [DW-1:0] div_ratio [2];
  logic          div_run   [2];
  logic          div_tick  [2];

  assign div_ratio[0] = eps_div(1'b0, pulse_rate_sel);
  assign div_ratio[1] = eps_div(long_pulse_sel, pulse_rate_sel);
  // No load stops the divided pulses in both paths
  assign div_run[0]   = mode_fixed & ~NO_LOAD_FLAG;
  assign div_run[1]   = standalone & ~NO_LOAD_FLAG;

  for (genvar i = 0; i < 2; i++) begin : g_div
    logic [DW-1:0] cnt_q;
    logic          last;

    assign last        = (cnt_q >= div_ratio[i] - {{(DW-1){1'b0}}, 1'b1});
    assign div_tick[i] = div_run[i] & aw_rise & last;

    // Count held, not cleared, during no load so no energy is lost
    always_ff @(posedge CLK) begin
      if (RST) begin
        cnt_q <= '0;
      end else if (CE) begin
        if (!standalone) begin
          cnt_q <= '0;
        end else if (div_run[i] && aw_rise) begin
          cnt_q <= last ? '0 : cnt_q + {{(DW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ****************************************************************
  // One-shots
  // ****************************************************************
  // Long select widens only the motor pulse; the pin width stays short
  localparam logic [CNT_W-1:0] SHORT_LEN = CNT_W'(SHORT_PULSE_CYC);
  localparam logic [CNT_W-1:0] LONG_LEN  = CNT_W'(LONG_PULSE_CYC);

  logic             led_os_clr;
  logic             led_os_pulse;
  logic             mot_os_clr;
  logic             mot_os_fire;
  logic             mot_os_pulse;
  logic [CNT_W-1:0] mot_len;

  assign led_os_clr = ~mode_fixed | NO_LOAD_FLAG;
  assign mot_os_clr = ~standalone | NO_LOAD_FLAG;
  assign mot_len    = long_pulse_sel ? LONG_LEN : SHORT_LEN;

  eps_oneshot #(
    .CNT_W (CNT_W)
  ) u_led_os (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .clr   (led_os_clr),
    .trig  (div_tick[0]),
    .len   (SHORT_LEN),
    .fire  (),
    .pulse (led_os_pulse)
  );

  eps_oneshot #(
    .CNT_W (CNT_W)
  ) u_mot_os (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .clr   (mot_os_clr),
    .trig  (div_tick[1]),
    .len   (mot_len),
    .fire  (mot_os_fire),
    .pulse (mot_os_pulse)
  );

  // ****************************************************************
  // Phase decoder
  // ****************************************************************
  // Phase is latched at pulse start so a pulse never swaps phase
  // Leaving the standalone modes restarts the sequence on phase A
  logic phase_next_q;
  logic phase_sel_q;
  logic phase_a;
  logic phase_b;

  always_ff @(posedge CLK) begin
    if (RST) begin
      phase_next_q <= 1'b0;
      phase_sel_q  <= 1'b0;
    end else if (CE) begin
      if (!standalone) begin
        phase_next_q <= 1'b0;
        phase_sel_q  <= 1'b0;
      end else if (mot_os_fire) begin
        phase_sel_q  <= phase_next_q;
        phase_next_q <= ~phase_next_q;
      end
    end
  end

  assign phase_a = mot_os_pulse & ~phase_sel_q;
  assign phase_b = mot_os_pulse & phase_sel_q;

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic calib_q;
  logic calib_d;
  logic pos_q;
  logic pos_d;
  logic neg_q;
  logic neg_d;

  always_comb begin
    calib_d = 1'b0;
    if (mode_direct) begin
      // Direct follow keeps the source waveform and its duty
      calib_d = ACTIVE_ENERGY_PULSE;
    end else if (mode_fixed) begin
      calib_d = led_os_pulse;
    end
  end

  always_comb begin
    pos_d = 1'b0;
    neg_d = 1'b0;
    // With load, sign flips the idle level too, so a stopped motor sits high
    if (standalone && !NO_LOAD_FLAG) begin
      pos_d = phase_a ^ POWER_NEGATIVE;
      neg_d = phase_b ^ POWER_NEGATIVE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      calib_q <= 1'b0;
    end else if (CE) begin
      calib_q <= calib_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (CE) begin
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign CALIB_PULSE_PIN = calib_q;
  assign MOTOR_OUT_POS   = pos_q;
  assign MOTOR_OUT_NEG   = neg_q;

  // ****************************************************************
  // Motor step counter
  // ****************************************************************
  // A step landing on the clear cycle still counts
  logic [15:0] step_q;
  logic        step_clr;

  assign step_clr = WR && (ADDR == eps_pkg::REG_STEP_LO);

  always_ff @(posedge CLK) begin
    if (RST) begin
      step_q <= 16'h0000;
    end else if (CE) begin
      if (mot_os_fire) begin
        step_q <= step_clr ? 16'h0001 : step_q + 16'h0001;
      end else if (step_clr) begin
        step_q <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Unmapped offsets read as zero; writes to them are dropped
  logic [7:0] status;
  logic [7:0] rdata_q;

  always_comb begin
    status                       = 8'h00;
    status[eps_pkg::ST_LED]      = calib_q;
    status[eps_pkg::ST_POS]      = pos_q;
    status[eps_pkg::ST_NEG]      = neg_q;
    status[eps_pkg::ST_PH_A]     = phase_a;
    status[eps_pkg::ST_PH_B]     = phase_b;
    status[eps_pkg::ST_MOT_BSY]  = mot_os_pulse;
    status[eps_pkg::ST_LED_BSY]  = led_os_pulse;
    status[eps_pkg::ST_NOLOAD]   = NO_LOAD_FLAG;
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else if (CE) begin
      rdata_q <= 8'h00;
      if (RD) begin
        case (ADDR)
          eps_pkg::REG_CFG:     rdata_q <= cfg_q;
          eps_pkg::REG_STATUS:  rdata_q <= status;
          eps_pkg::REG_STEP_LO: rdata_q <= step_q[7:0];
          eps_pkg::REG_STEP_HI: rdata_q <= step_q[15:8];
          default:              rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign RDATA = rdata_q;

endmodule : eps_driver

/* hdl/eps_oneshot.sv */
// Retriggerless one-shot producing fixed-width pulses
`timescale 1ns/1ns

module eps_oneshot #(
  parameter int unsigned CNT_W = 24
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             clr,
  input  wire logic             trig,
  input  wire logic [CNT_W-1:0] len,
  output logic                  fire,
  output logic                  pulse
);

  if (CNT_W < 2) begin : g_chk_w
    $error("eps_oneshot: CNT_W too small");
  end

  typedef enum logic [0:0] {
    EPS_OS_IDLE   = 1'b0,
    EPS_OS_ACTIVE = 1'b1
  } eps_os_state_e;

  eps_os_state_e    state_q;
  eps_os_state_e    state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // ****************************************************************
  // Start and countdown
  // ****************************************************************
  // Triggers during an active pulse are dropped, never extend it
  assign fire = trig & ~clr & (state_q == EPS_OS_IDLE);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      EPS_OS_IDLE: begin
        if (fire) begin
          state_d = EPS_OS_ACTIVE;
          cnt_d   = len - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      EPS_OS_ACTIVE: begin
        if (cnt_q == '0) begin
          state_d = EPS_OS_IDLE;
        end else begin
          cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        state_d = EPS_OS_IDLE;
      end
    endcase
    if (clr) begin
      state_d = EPS_OS_IDLE;
      cnt_d   = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= EPS_OS_IDLE;
      cnt_q   <= '0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign pulse = (state_q == EPS_OS_ACTIVE);

endmodule : eps_oneshot

/* hdl/eps_pkg.sv */
// Constants shared by the energy pulse stepper driver and its checker
package eps_pkg;

  // ****************************************************************
  // Clock and pulse timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned SHORT_PULSE_US = 31250;
  localparam int unsigned LONG_PULSE_US  = 156250;
  localparam int unsigned SHORT_PULSE_CYC = SHORT_PULSE_US * CLK_MHZ;
  localparam int unsigned LONG_PULSE_CYC  = LONG_PULSE_US * CLK_MHZ;
  localparam int unsigned CNT_W_DEF       = 24;

  // ****************************************************************
  // Output pin modes
  // ****************************************************************
  localparam logic [1:0] MODE_DIRECT = 2'h2;
  localparam logic [1:0] MODE_FIXED  = 2'h3;

  // ****************************************************************
  // Pulse dividers
  // ****************************************************************
  localparam int unsigned DIV_W = 12;
  localparam logic [11:0] DIV_64   = 12'h040;
  localparam logic [11:0] DIV_128  = 12'h080;
  localparam logic [11:0] DIV_32   = 12'h020;
  localparam logic [11:0] DIV_256  = 12'h100;
  localparam logic [11:0] DIV_640  = 12'h280;
  localparam logic [11:0] DIV_1280 = 12'h500;
  localparam logic [11:0] DIV_320  = 12'h140;
  localparam logic [11:0] DIV_2560 = 12'hA00;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [2:0] REG_CFG     = 3'h0;
  localparam logic [2:0] REG_STATUS  = 3'h1;
  localparam logic [2:0] REG_STEP_LO = 3'h2;
  localparam logic [2:0] REG_STEP_HI = 3'h3;
  localparam logic [7:0] CFG_RESET   = 8'h00;

  // Configuration fields
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_RATE_LSB = 2;
  localparam int unsigned CFG_LONG_BIT = 4;

  // Status fields
  localparam int unsigned ST_LED     = 0;
  localparam int unsigned ST_POS     = 1;
  localparam int unsigned ST_NEG     = 2;
  localparam int unsigned ST_PH_A    = 3;
  localparam int unsigned ST_PH_B    = 4;
  localparam int unsigned ST_MOT_BSY = 5;
  localparam int unsigned ST_LED_BSY = 6;
  localparam int unsigned ST_NOLOAD  = 7;

endpackage : eps_pkg

/* testbench/eps_driver_assertions.sv */
// Port checker for the energy pulse stepper driver
`timescale 1ns/1ns

module eps_driver_chk #(
  parameter int unsigned SHORT_PULSE_CYC = 4,
  parameter int unsigned LONG_PULSE_CYC  = 20
) (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CE,
  input wire logic       ACTIVE_ENERGY_PULSE,
  input wire logic       POWER_NEGATIVE,
  input wire logic       NO_LOAD_FLAG,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       CALIB_PULSE_PIN,
  input wire logic       MOTOR_OUT_POS,
  input wire logic       MOTOR_OUT_NEG
);
  // Frozen cycles carry no checks; the design holds its state there
  default clocking @(posedge CLK); endclocking
  default disable iff (RST || !CE);

  // ********************
  // Mirrored state
  // ********************
  logic [4:0]  cfg_q;
  logic        pn_q;
  logic [1:0]  last_q;
  int unsigned led_n_q;
  int unsigned mot_n_q;
  logic        pa;
  logic        pb;
  logic        mot;

  // Phases seen through the inversion; valid while the sign is steady
  assign pa  = MOTOR_OUT_POS ^ pn_q;
  assign pb  = MOTOR_OUT_NEG ^ pn_q;
  assign mot = pa | pb;

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_q <= 5'h00;
    end else if (CE && WR && ADDR == eps_pkg::REG_CFG) begin
      cfg_q <= WDATA[4:0];
    end
  end

  always_ff @(posedge CLK) begin
    pn_q    <= POWER_NEGATIVE;
    led_n_q <= CALIB_PULSE_PIN ? led_n_q + 1 : 0;
    mot_n_q <= mot ? mot_n_q + 1 : 0;
  end

  always_ff @(posedge CLK) begin
    if (RST || !cfg_q[1]) begin
      last_q <= 2'h0;
    end else if ($rose(pa)) begin
      last_q <= 2'h1;
    end else if ($rose(pb)) begin
      last_q <= 2'h2;
    end
  end

  // ********************
  // Properties
  // ********************

  sequence s_nl2;
    NO_LOAD_FLAG [*2];
  endsequence

  sequence s_led_end;
    $fell(CALIB_PULSE_PIN) && cfg_q[1:0] == 2'h3 && !$past(NO_LOAD_FLAG);
  endsequence

  sequence s_mot_end;
    $fell(mot) && cfg_q[1] && !$past(NO_LOAD_FLAG);
  endsequence

  property p_rst;
    $fell(RST) |-> !CALIB_PULSE_PIN && !MOTOR_OUT_POS && !MOTOR_OUT_NEG;
  endproperty
  property p_rdata;
    !$past(RD) |-> RDATA == 8'h00;
  endproperty
  property p_off;
    !cfg_q[1] && !$past(cfg_q[1]) && !$past(cfg_q[1], 2)
      |-> !CALIB_PULSE_PIN && !MOTOR_OUT_POS && !MOTOR_OUT_NEG;
  endproperty
  property p_direct;
    cfg_q[1:0] == 2'h2 && $past(cfg_q[1:0]) == 2'h2
      |-> CALIB_PULSE_PIN == $past(ACTIVE_ENERGY_PULSE);
  endproperty
  property p_nl;
    s_nl2 |=> !MOTOR_OUT_POS && !MOTOR_OUT_NEG
              && !(cfg_q[1:0] == 2'h3 && CALIB_PULSE_PIN);
  endproperty
  property p_ledw;
    s_led_end |-> led_n_q == SHORT_PULSE_CYC;
  endproperty
  property p_motw;
    s_mot_end |-> mot_n_q == (cfg_q[4] ? LONG_PULSE_CYC : SHORT_PULSE_CYC);
  endproperty
  property p_alt;
    $rose(mot) && cfg_q[1]
      |-> !(pa && pb) && (pb ? last_q == 2'h1 : last_q != 2'h1);
  endproperty
  property p_inv;
    MOTOR_OUT_POS && MOTOR_OUT_NEG |-> pn_q;
  endproperty

  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
  a_rdata: assert property (p_rdata)
    else $error("read data outside read slot");
  a_off: assert property (p_off)
    else $error("outputs active outside standalone modes");
  a_direct: assert property (p_direct)
    else $error("direct pin does not follow energy pulse");
  a_nl: assert property (p_nl)
    else $error("outputs active during no load");
  a_ledw: assert property (p_ledw)
    else $error("fixed pin pulse width wrong");
  a_motw: assert property (p_motw)
    else $error("motor pulse width wrong");
  a_alt: assert property (p_alt)
    else $error("motor phases do not alternate");
  a_inv: assert property (p_inv)
    else $error("both motor pins high with positive power");

endmodule : eps_driver_chk

bind eps_driver eps_driver_chk #(
  .SHORT_PULSE_CYC(SHORT_PULSE_CYC),
  .LONG_PULSE_CYC (LONG_PULSE_CYC)
) u_chk (
  .CLK                (CLK),
  .RST                (RST),
  .CE                 (CE),
  .ACTIVE_ENERGY_PULSE(ACTIVE_ENERGY_PULSE),
  .POWER_NEGATIVE     (POWER_NEGATIVE),
  .NO_LOAD_FLAG       (NO_LOAD_FLAG),
  .ADDR               (ADDR),
  .WDATA              (WDATA),
  .WR                 (WR),
  .RD                 (RD),
  .RDATA              (RDATA),
  .CALIB_PULSE_PIN    (CALIB_PULSE_PIN),
  .MOTOR_OUT_POS      (MOTOR_OUT_POS),
  .MOTOR_OUT_NEG      (MOTOR_OUT_NEG)
);

/* testbench/eps_motor_model.sv */
// Behavioural stepper motor and calibration pulse counter
`timescale 1ns/1ns

module eps_motor_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic calib_pulse_pin,
  input wire logic pos,
  input wire logic neg,
  output int       led_cnt,
  output int       pos_cnt,
  output int       neg_cnt
);
  logic       led_q;
  logic [1:0] coil_q;

  // Idle 00 and 11 carry no coil current; count each energising once
  always_ff @(posedge clk) begin
    led_q  <= calib_pulse_pin;
    coil_q <= {pos, neg};
    if (rst) begin
      led_cnt <= 0;
      pos_cnt <= 0;
      neg_cnt <= 0;
    end else begin
      if (calib_pulse_pin && !led_q) led_cnt <= led_cnt + 1;
      if ({pos, neg} == 2'h2 && coil_q != 2'h2) pos_cnt <= pos_cnt + 1;
      if ({pos, neg} == 2'h1 && coil_q != 2'h1) neg_cnt <= neg_cnt + 1;
    end
  end
endmodule : eps_motor_model

/* testbench/testbench.sv */
// Self-checking bench for the energy pulse stepper driver
`timescale 1ns/1ns

module testbench;
  logic       clk   = 1'h0;
  logic       rst   = 1'h1;
  logic       ce    = 1'h1;
  logic       aep   = 1'h0;
  logic       pn    = 1'h0;
  logic       nl    = 1'h0;
  logic [2:0] addr  = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'h0;
  logic       rd    = 1'h0;
  logic [7:0] rdata;
  logic       calib_pulse_pin;
  logic       pos;
  logic       neg;
  int         lc;
  int         pc;
  int         nc;
  int         fail_count = 0;
  int         num_checks = 0;
  int         mot[8] = '{64, 128, 32, 256, 640, 1280, 320, 2560};
  int         dv[4]  = '{64, 128, 32, 256};

  always #5 clk = ~clk;

  // Short pulse lengths keep the long divide ratios affordable
  eps_driver #(
    .SHORT_PULSE_CYC(4),
    .LONG_PULSE_CYC (20)
  ) dut (
    .CLK                (clk),
    .RST                (rst),
    .CE                 (ce),
    .ACTIVE_ENERGY_PULSE(aep),
    .POWER_NEGATIVE     (pn),
    .NO_LOAD_FLAG       (nl),
    .ADDR               (addr),
    .WDATA              (wdata),
    .WR                 (wr),
    .RD                 (rd),
    .RDATA              (rdata),
    .CALIB_PULSE_PIN    (calib_pulse_pin),
    .MOTOR_OUT_POS      (pos),
    .MOTOR_OUT_NEG      (neg)
  );

  eps_motor_model u_mot (
    .clk    (clk),
    .rst    (rst),
    .calib_pulse_pin    (calib_pulse_pin),
    .pos    (pos),
    .neg    (neg),
    .led_cnt(lc),
    .pos_cnt(pc),
    .neg_cnt(nc)
  );

  // ********************
  // Helpers
  // ********************
  task chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("ERROR %0t: %s", $time, m);
    end
  endtask : chk

  task bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : bus_wr

  task bus_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    // Data stand for this one cycle; look mid-cycle, resume on the edge
    @(negedge clk);
    chk(rdata === e, "read data");
    @(posedge clk);
  endtask : bus_rd

  // Half the period high: the energy pulse has a 50 percent duty
  task pulses(input int n);
    repeat (n) begin
      aep <= 1'h1;
      repeat (2) @(posedge clk);
      aep <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask : pulses

  // Mode 0 first so every run starts on phase A with empty dividers
  task run(input logic [7:0] c, input logic ng, input int n,
           input int el, input int ep, input int en);
    int l0;
    int p0;
    int n0;
    bus_wr(3'h0, 8'h00);
    bus_wr(3'h0, c);
    bus_rd(3'h0, c);
    pn <= ng;
    l0 = lc;
    p0 = pc;
    n0 = nc;
    pulses(n);
    repeat (40) @(posedge clk);
    chk(lc - l0 === el, "pin pulse count");
    chk(pc - p0 === ep, "positive coil pulse count");
    chk(nc - n0 === en, "negative coil pulse count");
    pn <= 1'h0;
  endtask : run

  // Clock enable low: pulses and a write must leave no trace
  task freeze;
    int l0;
    bus_wr(3'h0, 8'h02);
    l0 = lc;
    ce <= 1'h0;
    pulses(8);
    bus_wr(3'h0, 8'h00);
    ce <= 1'h1;
    repeat (4) @(posedge clk);
    chk(lc === l0, "pin moved while frozen");
    bus_rd(3'h0, 8'h02);
  endtask : freeze

  task end_sim;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // ********************
  // Scenarios
  // ********************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    bus_rd(3'h0, 8'h00);
    bus_rd(3'h1, 8'h00);
    bus_wr(3'h6, 8'hFF);
    bus_rd(3'h6, 8'h00);
    bus_rd(3'h0, 8'h00);
    run(8'h01, 1'h0, 64, 0, 0, 0);
    run(8'h02, 1'h0, 128, 128, 1, 1);
    for (int i = 0; i < 8; i++) begin
      run(8'h03 | 8'(i << 2), 1'h0, 2 * mot[i],
          2 * mot[i] / dv[i % 4], 1, 1);
    end
    bus_wr(3'h0, 8'h0B);
    pn <= 1'h1;
    bus_rd(3'h1, 8'h06);
    pn <= 1'h0;
    run(8'h0B, 1'h1, 64, 2, 1, 1);
    nl <= 1'h1;
    run(8'h0B, 1'h0, 64, 0, 0, 0);
    bus_rd(3'h1, 8'h80);
    run(8'h02, 1'h0, 64, 64, 0, 0);
    nl <= 1'h0;
    bus_rd(3'h2, 8'h14);
    bus_rd(3'h3, 8'h00);
    bus_wr(3'h2, 8'h00);
    bus_rd(3'h2, 8'h00);
    freeze;
    end_sim;
  end
endmodule : testbench
